// File: tcc_pkg.sv
// constants, register map and mode codes for the capture/compare timer
package tcc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  // register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_COUNT_HIGH = 12'h000;
  localparam logic [ADDR_W-1:0] IDX_COUNT_LOW = 12'h001;
  localparam logic [ADDR_W-1:0] IDX_RELOAD_HIGH = 12'h002;
  localparam logic [ADDR_W-1:0] IDX_RELOAD_LOW = 12'h003;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_HIGH = 12'h004;
  localparam logic [ADDR_W-1:0] IDX_CAPTURE_LOW = 12'h005;
  localparam logic [ADDR_W-1:0] IDX_CONTROL_ONE = 12'h007;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h008;

  // control one field positions
  localparam int unsigned CTL_ENABLE_BIT = 7;
  localparam int unsigned CTL_POLARITY_BIT = 6;
  localparam int unsigned CTL_PRESCALE_HI = 5;
  localparam int unsigned CTL_PRESCALE_LO = 3;
  localparam int unsigned CTL_MODE_HI = 2;
  localparam int unsigned CTL_MODE_LO = 0;

  // values after reset, plus restart value, count step and prescale unit constants
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'hffff;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [6:0] PRESCALE_ONE = 7'h01;

  typedef enum logic [2:0] {
    TCC_MODE_IDLE0   = 3'b000,
    TCC_MODE_IDLE1   = 3'b001,
    TCC_MODE_IDLE2   = 3'b010,
    TCC_MODE_IDLE3   = 3'b011,
    TCC_MODE_CAPTURE = 3'b100,
    TCC_MODE_COMPARE = 3'b101,
    TCC_MODE_GATED   = 3'b110,
    TCC_MODE_CAPCMP  = 3'b111
  } tcc_mode_t;

  // last prescale count, one less than the divide ratio of 2 to the power of the field
  function automatic logic [6:0] tccPrescaleLast(input logic [2:0] sel);
    tccPrescaleLast = 7'((PRESCALE_ONE << sel) - PRESCALE_ONE);
  endfunction

endpackage

// File: tcc_input_edge.sv
// timer input synchroniser with one-cycle edge events
`timescale 1ns/1ps
module tcc_input_edge (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic levelOut,
  output logic risePulse,
  output logic fallPulse
);

  logic syncA_q;
  logic syncB_q;
  logic prev_q;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end

  assign levelOut = syncB_q;
  assign risePulse = syncB_q & ~prev_q;
  assign fallPulse = ~syncB_q & prev_q;

endmodule // tcc_input_edge

// File: tcc_timer.sv
// capture, compare, gated and capture-then-compare timer with apb registers
`timescale 1ns/1ps
module tcc_timer
  import tcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timerIn,
  output logic timerOut,
  output logic timerIrq
);

  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic timerOut_q;
  logic timerIrq_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] reload_q;
  logic [7:0] reloadTemp_q;
  logic [15:0] capture_q;
  logic [7:0] holdLow_q;
  logic [7:0] control_q;
  logic [6:0] prescale_q;
  logic started_q;
  logic lastIrq_q;

  logic inLevel;
  logic inRise;
  logic inFall;
  logic enabled;
  logic polarity;
  tcc_mode_t mode;
  logic tick;
  logic selEdge;
  logic gateActive;
  logic gateDrop;
  logic atReload;
  logic apbDone;
  logic apbWrite;
  logic apbRead;
  logic [ADDR_W-1:0] regIdx;
  logic mapped;
  logic captureNow;
  logic restartNow;
  logic toggleNow;
  logic irqNow;
  logic [7:0] wByte;

  tcc_input_edge u_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(timerIn),
    .levelOut(inLevel),
    .risePulse(inRise),
    .fallPulse(inFall)
  );

  assign enabled = control_q[CTL_ENABLE_BIT];
  assign polarity = control_q[CTL_POLARITY_BIT];
  assign mode = tcc_mode_t'(control_q[CTL_MODE_HI:CTL_MODE_LO]);
  assign wByte = pwdata[7:0];

  // word-aligned index; low address bits ignored
  assign regIdx = {2'b00, paddr[ADDR_W-1:2]};
  assign apbDone = psel & penable & pready_q;
  assign apbWrite = apbDone & pwrite;
  // read sampling edge; while enabled, low byte held at the same instant as the high byte
  assign apbRead = psel & penable & ~pready_q & ~pwrite;

  function automatic logic isMapped(input logic [ADDR_W-1:0] idx);
    isMapped = (idx == IDX_COUNT_HIGH) || (idx == IDX_COUNT_LOW) ||
               (idx == IDX_RELOAD_HIGH) || (idx == IDX_RELOAD_LOW) ||
               (idx == IDX_CAPTURE_HIGH) || (idx == IDX_CAPTURE_LOW) ||
               (idx == IDX_CONTROL_ONE) || (idx == IDX_STATUS);
  endfunction

  assign mapped = isMapped(regIdx);

  assign selEdge = polarity ? inFall : inRise;
  assign gateActive = inLevel ^ polarity;
  assign gateDrop = polarity ? inRise : inFall;

  assign tick = enabled && (prescale_q ==
    tccPrescaleLast(control_q[CTL_PRESCALE_HI:CTL_PRESCALE_LO]));
  assign atReload = (count_q == reload_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= 7'h00;
    end else if (!enabled || tick) begin
      prescale_q <= 7'h00;
    end else begin
      prescale_q <= 7'(prescale_q + PRESCALE_ONE);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q <= 1'b0;
    end else if (!enabled || mode != TCC_MODE_CAPCMP) begin
      started_q <= 1'b0;
    end else if (selEdge) begin
      started_q <= 1'b1;
    end
  end

  // per-mode event decode
  always_comb begin
    captureNow = 1'b0;
    restartNow = 1'b0;
    toggleNow = 1'b0;
    irqNow = 1'b0;
    count_d = count_q;
    if (enabled) begin
      unique case (mode)
        TCC_MODE_CAPTURE: begin
          if (selEdge) begin
            captureNow = 1'b1;
            irqNow = 1'b1;
          end
          if (tick && atReload) begin
            irqNow = 1'b1;
            toggleNow = 1'b1;
          end
          if (tick) begin
            count_d = 16'(count_q + COUNT_STEP);
          end
        end
        TCC_MODE_COMPARE: begin
          if (tick && atReload) begin
            irqNow = 1'b1;
            toggleNow = 1'b1;
          end
          if (tick) begin
            count_d = 16'(count_q + COUNT_STEP);
          end
        end
        TCC_MODE_GATED: begin
          if (gateDrop) begin
            irqNow = 1'b1;
          end
          if (tick && gateActive) begin
            if (atReload) begin
              irqNow = 1'b1;
              count_d = COUNT_RESTART;
              toggleNow = 1'b1;
            end else begin
              count_d = 16'(count_q + COUNT_STEP);
            end
          end
        end
        TCC_MODE_CAPCMP: begin
          if (started_q && selEdge) begin
            captureNow = 1'b1;
            irqNow = 1'b1;
            restartNow = 1'b1;
            toggleNow = 1'b1;
          end else if (started_q && tick && atReload) begin
            irqNow = 1'b1;
            restartNow = 1'b1;
            toggleNow = 1'b1;
          end else if (started_q && tick) begin
            count_d = 16'(count_q + COUNT_STEP);
          end
          if (restartNow) begin
            count_d = COUNT_RESTART;
          end
        end
        default: begin
          // remaining idle mode codes raise no events; hold the count
          count_d = count_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= COUNT_RESET;
    end else if (apbWrite && regIdx == IDX_COUNT_HIGH) begin
      count_q <= {wByte, count_d[7:0]};
    end else if (apbWrite && regIdx == IDX_COUNT_LOW) begin
      count_q <= {count_d[15:8], wByte};
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reloadTemp_q <= RELOAD_RESET[15:8];
      reload_q <= RELOAD_RESET;
    end else if (apbWrite && regIdx == IDX_RELOAD_HIGH) begin
      reloadTemp_q <= wByte;
    end else if (apbWrite && regIdx == IDX_RELOAD_LOW) begin
      reload_q <= {reloadTemp_q, wByte};
    end
  end

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_q <= CAPTURE_RESET;
    end else if (captureNow) begin
      capture_q <= count_q;
    end else if (apbWrite && regIdx == IDX_CAPTURE_HIGH) begin
      capture_q <= {wByte, capture_q[7:0]};
    end else if (apbWrite && regIdx == IDX_CAPTURE_LOW) begin
      capture_q <= {capture_q[15:8], wByte};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET;
    end else if (apbWrite && regIdx == IDX_CONTROL_ONE) begin
      control_q <= wByte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdLow_q <= 8'h00;
    end else if (enabled && apbRead && regIdx == IDX_COUNT_HIGH) begin
      holdLow_q <= count_q[7:0];
    end
  end

  // disabled output follows polarity
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerOut_q <= 1'b0;
    end else if (!enabled) begin
      timerOut_q <= polarity;
    end else if (toggleNow) begin
      timerOut_q <= ~timerOut_q;
    end
  end

  // one-cycle interrupt request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerIrq_q <= 1'b0;
      lastIrq_q <= 1'b0;
    end else begin
      timerIrq_q <= irqNow;
      if (irqNow) begin
        lastIrq_q <= captureNow;
      end
    end
  end

  // one wait state keeps prdata registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= ~mapped;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
    end else if (psel && penable && !pready_q && !pwrite) begin
      prdata_q <= '0;
      unique case (regIdx)
        IDX_COUNT_HIGH: prdata_q[7:0] <= count_q[15:8];
        IDX_COUNT_LOW: prdata_q[7:0] <= enabled ? holdLow_q : count_q[7:0];
        IDX_RELOAD_HIGH: prdata_q[7:0] <= reload_q[15:8];
        IDX_RELOAD_LOW: prdata_q[7:0] <= reload_q[7:0];
        IDX_CAPTURE_HIGH: prdata_q[7:0] <= capture_q[15:8];
        IDX_CAPTURE_LOW: prdata_q[7:0] <= capture_q[7:0];
        IDX_CONTROL_ONE: prdata_q[7:0] <= control_q;
        IDX_STATUS: prdata_q[3:0] <= {lastIrq_q, started_q, gateActive, inLevel};
        default: prdata_q <= '0;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timerOut = timerOut_q;
  assign timerIrq = timerIrq_q;

endmodule // tcc_timer

// File: tcc_timer_sva.sv
// port-level assertion checker for the capture/compare timer
`timescale 1ns/1ps
module tcc_timer_sva
  import tcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic timerIn,
  input wire logic timerOut,
  input wire logic timerIrq
);
  logic [7:0] ctlQ;
  logic [3:0] stCnt;
  logic pinQ;
  logic ccSeenQ;
  logic ctlWr;
  logic en;
  logic pol;
  logic [2:0] mode;
  logic edgeSel;
  logic edgeLeave;
  logic ccMode;
  // shadow of the control register, taken at the completion edge
  assign ctlWr = psel && penable && pready && pwrite && (paddr[11:2] == IDX_CONTROL_ONE[9:0]);
  assign en = ctlQ[CTL_ENABLE_BIT];
  assign pol = ctlQ[CTL_POLARITY_BIT];
  assign mode = ctlQ[CTL_MODE_HI:CTL_MODE_LO];
  assign edgeSel = en && (timerIn != pinQ) && (timerIn != pol);
  assign edgeLeave = en && (timerIn != pinQ) && (timerIn == pol);
  assign ccMode = en && (mode == TCC_MODE_CAPCMP);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlQ <= CONTROL_RESET;
      stCnt <= 4'h0;
    end else begin
      if (ctlWr) ctlQ <= pwdata[7:0];
      stCnt <= ctlWr ? 4'h0 : stCnt + {3'h0, stCnt != 4'hf};
    end
  end
  // edge history; the first selected edge only arms capture-then-compare
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinQ <= 1'b0;
      ccSeenQ <= 1'b0;
    end else begin
      pinQ <= timerIn;
      ccSeenQ <= ccMode && (ccSeenQ || edgeSel);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_irq_single_pulse: assert property (timerIrq |=> !timerIrq)
    else $error("interrupt pulse longer than one cycle");
  a_cap_edge_irq: assert property ((mode == TCC_MODE_CAPTURE) && edgeSel |-> ##[2:6] timerIrq)
    else $error("capture edge gave no interrupt");
  a_gate_leave_irq: assert property ((mode == TCC_MODE_GATED) && edgeLeave |-> ##[2:6] timerIrq)
    else $error("gate release gave no interrupt");
  a_cc_first_quiet: assert property (ccMode && !ccSeenQ && edgeSel |=> !timerIrq [*7])
    else $error("first start edge raised an interrupt");
  a_cc_later_irq: assert property (ccMode && ccSeenQ && edgeSel |-> ##[2:6] timerIrq)
    else $error("later capture edge gave no interrupt");
  a_off_irq_quiet: assert property (!en && stCnt > 4'h4 |-> !timerIrq)
    else $error("interrupt while timer disabled");
  a_off_out_level: assert property (!en && stCnt > 4'h2 |-> timerOut == pol)
    else $error("disabled output differs from polarity");
  a_toggle_with_irq: assert property (en && stCnt > 4'h3 && $changed(timerOut)
    |-> (timerIrq || $past(timerIrq)) or (##1 timerIrq))
    else $error("output toggled without a reload event");
  c_capture: cover property ((mode == TCC_MODE_CAPTURE) && edgeSel);
  c_cc_later: cover property (ccMode && ccSeenQ && edgeSel);
  c_toggle: cover property (en && $changed(timerOut));
endmodule // tcc_timer_sva

// File: tcc_pin_model.sv
// timer input pin source with programmable lag
`timescale 1ns/1ps
module tcc_pin_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wantLevel,
  input wire logic [1:0] lagCycles,
  output logic pinLevel
);
  logic [1:0] waitQ;
  // a slow source holds the old level until its lag has run out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinLevel <= 1'b0;
      waitQ <= 2'h0;
    end else if (wantLevel == pinLevel) begin
      waitQ <= 2'h0;
    end else if (waitQ >= lagCycles) begin
      pinLevel <= wantLevel;
      waitQ <= 2'h0;
    end else begin
      waitQ <= waitQ + 2'h1;
    end
  end
endmodule // tcc_pin_model

// File: tcc_timer_tb.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module tcc_timer_tb
  import tcc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, timerIn, timerOut, timerIrq, err, pol;
  logic wantLevel = 1'b0;
  logic [1:0] lagCycles = 2'h0;
  logic [2:0] presc = 3'h0;
  logic [DATA_W-1:0] rd;
  logic [15:0] cnt, cap;
  int n_errors = 0;
  int total_checks = 0;
  int irqCnt = 0;
  int base;
  tcc_timer u_tcc_timer (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timerIn(timerIn), .timerOut(timerOut), .timerIrq(timerIrq));
  tcc_pin_model u_tcc_pin_model (.ref_clk(ref_clk), .rst_n(rst_n), .wantLevel(wantLevel),
    .lagCycles(lagCycles), .pinLevel(timerIn));
  always #12.5 ref_clk = ~ref_clk;
  // counted on the falling edge to stay clear of the bench's own sampling
  always @(negedge ref_clk) if (timerIrq === 1'b1) irqCnt++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic apb(input logic [ADDR_W-1:0] idx, input logic wr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic rd16(input logic [ADDR_W-1:0] hi, input logic [ADDR_W-1:0] lo,
    output logic [15:0] v);
    apb(hi, 1'b0, 8'h00);
    v[15:8] = rd[7:0];
    apb(lo, 1'b0, 8'h00);
    v[7:0] = rd[7:0];
  endtask
  task automatic wr16(input logic [ADDR_W-1:0] hi, input logic [ADDR_W-1:0] lo,
    input logic [15:0] v);
    apb(hi, 1'b1, v[15:8]);
    apb(lo, 1'b1, v[7:0]);
  endtask
  task automatic cfg(input tcc_mode_t m, input logic p, input logic [15:0] st,
    input logic [15:0] rl);
    apb(IDX_CONTROL_ONE, 1'b1, {1'b0, p, presc, m});
    wantLevel <= p;
    lagCycles <= 2'($urandom());
    wr16(IDX_COUNT_HIGH, IDX_COUNT_LOW, st);
    wr16(IDX_RELOAD_HIGH, IDX_RELOAD_LOW, rl);
    wr16(IDX_CAPTURE_HIGH, IDX_CAPTURE_LOW, 16'h0000);
    apb(IDX_CONTROL_ONE, 1'b1, {1'b1, p, presc, m});
    base = irqCnt;
  endtask
  initial begin
    void'($urandom(67250));
    tick(20);
    rst_n <= 1'b1;
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk(cnt, COUNT_RESET);
    rd16(IDX_CAPTURE_HIGH, IDX_CAPTURE_LOW, cnt);
    chk(cnt, CAPTURE_RESET);
    apb(IDX_CONTROL_ONE, 1'b0, 8'h00);
    chk({8'h00, rd[7:0]}, {8'h00, CONTROL_RESET});
    apb(12'h006, 1'b0, 8'h00);
    chk({err, rd[14:0]}, 16'h8000);
    apb(IDX_RELOAD_HIGH, 1'b1, 8'h12);
    rd16(IDX_RELOAD_HIGH, IDX_RELOAD_LOW, cnt);
    chk(cnt, RELOAD_RESET);
    apb(IDX_RELOAD_LOW, 1'b1, 8'h34);
    rd16(IDX_RELOAD_HIGH, IDX_RELOAD_LOW, cnt);
    chk(cnt, 16'h1234);
    cap = 16'($urandom());
    wr16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cap);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk(cnt, cap);
    for (int p = 0; p < 2; p++) begin
      cfg(TCC_MODE_CAPTURE, p[0], 16'h0001, 16'h0060);
      wantLevel <= ~p[0];
      tick(12);
      chk(16'(irqCnt - base), 16'h0001);
      rd16(IDX_CAPTURE_HIGH, IDX_CAPTURE_LOW, cap);
      rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
      chk({15'h0, cap != 16'h0 && cap < cnt}, 16'h0001);
      wantLevel <= p[0];
      tick(12);
      chk(16'(irqCnt - base), 16'h0001);
      tick(80);
      rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
      chk({15'h0, cnt > 16'h0060}, 16'h0001);
      chk(16'(irqCnt - base), 16'h0002);
    end
    pol = 1'($urandom());
    cfg(TCC_MODE_COMPARE, pol, 16'hfff0, 16'h0005);
    tick(40);
    chk(16'(irqCnt - base), 16'h0001);
    chk({15'h0, timerOut}, {15'h0, ~pol});
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({15'h0, cnt > 16'h0005 && cnt < 16'h0100}, 16'h0001);
    apb(IDX_COUNT_HIGH, 1'b1, 8'h80);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({8'h00, cnt[15:8]}, 16'h0080);
    apb(IDX_COUNT_HIGH, 1'b0, 8'h00);
    apb(IDX_COUNT_LOW, 1'b0, 8'h00);
    cap = {8'h00, rd[7:0]};
    tick(6);
    apb(IDX_COUNT_LOW, 1'b0, 8'h00);
    chk({8'h00, rd[7:0]}, cap);
    presc = 3'h2;
    cfg(TCC_MODE_COMPARE, 1'b0, 16'h0001, 16'hffff);
    presc = 3'h0;
    tick(40);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({15'h0, cnt > 16'h0008 && cnt < 16'h000e}, 16'h0001);
    cfg(TCC_MODE_GATED, 1'b0, 16'h0100, 16'h0120);
    tick(20);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk(cnt, 16'h0100);
    wantLevel <= 1'b1;
    tick(50);
    chk(16'(irqCnt - base), 16'h0001);
    chk({15'h0, timerOut}, 16'h0001);
    wantLevel <= 1'b0;
    tick(12);
    chk(16'(irqCnt - base), 16'h0002);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({15'h0, cnt > 16'h0 && cnt < 16'h0100}, 16'h0001);
    tick(20);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cap);
    chk(cap, cnt);
    pol = 1'($urandom());
    cfg(TCC_MODE_CAPCMP, pol, 16'h0001, 16'h0200);
    tick(20);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk(cnt, 16'h0001);
    wantLevel <= ~pol;
    tick(12);
    chk(16'(irqCnt - base), 16'h0000);
    wantLevel <= pol;
    tick(12);
    wantLevel <= ~pol;
    tick(12);
    chk(16'(irqCnt - base), 16'h0001);
    rd16(IDX_CAPTURE_HIGH, IDX_CAPTURE_LOW, cap);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({15'h0, cap > 16'h0010 && cnt < 16'h0020}, 16'h0001);
    tick(600);
    chk(16'(irqCnt - base), 16'h0002);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk({15'h0, cnt < 16'h0200}, 16'h0001);
    cfg(TCC_MODE_IDLE0, 1'b0, 16'h0042, 16'h0043);
    tick(20);
    rd16(IDX_COUNT_HIGH, IDX_COUNT_LOW, cnt);
    chk(cnt, 16'h0042);
    chk(16'(irqCnt - base), 16'h0000);
    apb(IDX_CONTROL_ONE, 1'b1, 8'h40);
    tick(10);
    chk({15'h0, timerOut}, 16'h0001);
    wrap_up();
  end
endmodule // tcc_timer_tb
bind tcc_timer tcc_timer_sva u_tcc_timer_sva (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .timerIn(timerIn), .timerOut(timerOut), .timerIrq(timerIrq));
